// ---- sysctrl_pkg.sv ----
// constants and types shared by the timer hold / system control bank
// Summary of operation
// [RULE1] resume bit 3 releases held watchdog
// [RULE2] resume bit 2 releases held radio timebase
// [RULE3] resume bit 1 releases held general timer
// [RULE4] resume bit 0 releases held wake-up timer
// [RULE5] halt_hold_enable set holds all timers in halt
// [RULE6] enable clear: halt holds follow hold flags
// [RULE7] watchdog always held during debug halt
// [RULE8] calibration_pending: programmed but not yet calibrated
// [RULE9] exchange_mem_split bits 5:1, reset code 1
// [RULE10] codes 9-15, 17-23 valid; 8,16,>23 reserved
// [RULE11] software holds wake request one low-power period
// [RULE12] deep sleep wake interrupt after 3-4 periods
// [RULE13] pulse style: steady high or fast clock/2
// [RULE14] prescale bypass: ON counter undivided, else /10
// [RULE15] clock source: fast clock or 32 kHz slow
// [RULE16] timer_run zero stops and resets timer
// [RULE17] on_reload write sets reload, read counter
// [RULE18] hold-request ones hold timers, zeros ignored
// [RULE19] watchdog software hold blocked when reset-only
// [RULE20] one hold flag per timer, reset clears
package sysctrl_pkg;
    // register indices (byte address is four times the index)
    localparam logic [31:0] IDX_TIMER_HOLD_SET = 32'h5000_3300;
    localparam logic [31:0] IDX_TIMER_RESUME = 32'h5000_3302;
    localparam logic [31:0] IDX_DEBUG_HALT_CONTROL = 32'h5000_3304;
    localparam logic [31:0] IDX_GENERAL_STATUS = 32'h5000_3306;
    localparam logic [31:0] IDX_GENERAL_CONTROL = 32'h5000_3308;
    localparam logic [31:0] IDX_TIMER_CONTROL = 32'h5000_3400;
    localparam logic [31:0] IDX_TIMER_ON_RELOAD = 32'h5000_3402;
    // number of index bits compared by the decoder
    localparam int DEC_BITS = 12;
    // hold flag positions
    localparam int HOLD_WDOG = 3;
    localparam int HOLD_RADIO = 2;
    localparam int HOLD_GTIMER = 1;
    localparam int HOLD_WAKEUP = 0;
    // field positions
    localparam int HALT_HOLD_EN_BIT = 0;
    localparam int CAL_PEND_BIT = 0;
    localparam int WAKE_REQ_BIT = 0;
    localparam int EM_SPLIT_LSB = 1;
    localparam int EM_SPLIT_MSB = 5;
    localparam int TC_STYLE_BIT = 3;
    localparam int TC_BYPASS_BIT = 2;
    localparam int TC_SOURCE_BIT = 1;
    localparam int TC_RUN_BIT = 0;
    // reset values
    localparam logic HALT_HOLD_EN_RST = 1'h1;
    localparam logic [4:0] EM_SPLIT_RST = 5'h01;
    // timing figures
    localparam int PRESCALE_DIV = 10;
    localparam logic [1:0] WAKE_LP_TICKS = 2'h3;
    // wake request sequencer
    typedef enum logic [1:0] {
        WK_IDLE = 2'b00,
        WK_WAIT = 2'b01,
        WK_DONE = 2'b10
    } wake_state_t;
endpackage : sysctrl_pkg

// ---- timer_freeze_sysctrl.sv ----
// timer hold, debug halt, memory split, radio wake and general timer bank
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module timer_freeze_sysctrl (
    input wire logic clk, // system clock, 100 MHz
    input wire logic rst, // synchronous reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic debug_halted, // processor halted in debug state
    input wire logic wdog_reset_only, // watchdog reset-only mode
    input wire logic otp_programmed, // otp initially programmed
    input wire logic calibration_done, // calibration performed
    input wire logic radio_deep_sleep, // radio core in deep sleep
    input wire logic lp_tick, // one pulse per low-power clock period
    input wire logic fast_tick, // one pulse per fast clock period
    input wire logic slow_tick, // one pulse per 32 kHz period
    output logic watchdog_held, // watchdog counter held
    output logic radio_timebase_held, // radio timebase held
    output logic sw_timer_held, // general timer held
    output logic wakeup_timer_held, // wake-up timer held
    output logic radio_wake_request, // wake request to radio
    output logic lp_wake_irq, // low-power wake interrupt pulse
    output logic [3:0] exchange_mem_kb, // exchange memory size
    output logic [5:0] system_mem_kb, // system memory size
    output logic exchange_mem_reserved, // split code reserved
    output logic pulse_out, // general timer pulse output
    output logic [15:0] on_phase_counter // live ON counter
);
    // whole state of the block
    typedef struct packed {
        logic [3:0] hold;
        logic [3:0] held;
        logic halt_hold_enable;
        logic cal_pend;
        logic [4:0] em_split;
        logic [3:0] em_kb;
        logic [5:0] sys_kb;
        logic em_rsv;
        logic wake_req;
        sysctrl_pkg::wake_state_t wk_state;
        logic [1:0] wk_cnt;
        logic wake_irq;
        logic [3:0] tctrl;
        logic [15:0] on_reload;
        logic [15:0] on_cnt;
        logic [3:0] pre_cnt;
        logic fast_half;
        logic pulse;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_t;

    state_t st_r; // registered state
    state_t st_nxt; // next state

    // address match against a register index
    function automatic logic reg_hit(input logic [31:0] addr, input logic [31:0] idx);
        reg_hit = (addr[sysctrl_pkg::DEC_BITS+1:2] == idx[sysctrl_pkg::DEC_BITS-1:0]);
    endfunction : reg_hit

    // split code to {reserved, exchange kB, system kB}
    function automatic logic [10:0] em_decode(input logic [4:0] code);
        logic [3:0] em;
        logic [5:0] sys;
        logic rsv;
        em = 4'h0;
        sys = 6'h2A;
        rsv = 1'b0;
        if (code == 5'h00) begin // no exchange memory
            em = 4'h0;
            sys = 6'h2A;
        end else if (code <= 5'h07) begin // 2..8 kB
            em = 4'(code + 5'h01);
            sys = 6'(6'h31 - {1'b0, code});
        end else if (code >= 5'h09 && code <= 5'h0F) begin // 4..10 kB, 40 kB system
            em = 4'(code - 5'h05);
            sys = 6'h28;
        end else if (code >= 5'h11 && code <= 5'h17) begin // 6..12 kB, 38 kB system
            em = 4'(code - 5'h0B);
            sys = 6'h26;
        end else begin // reserved codes
            rsv = 1'b1;
        end
        em_decode = {rsv, em, sys};
    endfunction : em_decode

    logic acc; // access phase, answer not yet given
    logic wr_done; // write takes effect this edge
    logic hit_any; // address maps to a register
    logic tick_sel; // selected timer clock tick
    logic on_tick; // ON counter step
    logic g_run; // general timer may advance
    logic [10:0] em_dec; // decoded split

    // next-state logic
    always_comb begin
        st_nxt = st_r;
        acc = psel && penable && !st_r.pready;
        wr_done = psel && penable && st_r.pready && pwrite;
        hit_any = reg_hit(paddr, sysctrl_pkg::IDX_TIMER_HOLD_SET) ||
                  reg_hit(paddr, sysctrl_pkg::IDX_TIMER_RESUME) ||
                  reg_hit(paddr, sysctrl_pkg::IDX_DEBUG_HALT_CONTROL) ||
                  reg_hit(paddr, sysctrl_pkg::IDX_GENERAL_STATUS) ||
                  reg_hit(paddr, sysctrl_pkg::IDX_GENERAL_CONTROL) ||
                  reg_hit(paddr, sysctrl_pkg::IDX_TIMER_CONTROL) ||
                  reg_hit(paddr, sysctrl_pkg::IDX_TIMER_ON_RELOAD);

        // apb answer, one wait state
        st_nxt.pready = acc;
        st_nxt.pslverr = acc && !hit_any;
        st_nxt.prdata = 32'h0000_0000;
        if (acc && !pwrite) begin // read mux
            if (reg_hit(paddr, sysctrl_pkg::IDX_TIMER_HOLD_SET) ||
                reg_hit(paddr, sysctrl_pkg::IDX_TIMER_RESUME)) begin
                st_nxt.prdata = {28'h0000000, st_r.hold};
            end else if (reg_hit(paddr, sysctrl_pkg::IDX_DEBUG_HALT_CONTROL)) begin
                st_nxt.prdata = {31'h00000000, st_r.halt_hold_enable};
            end else if (reg_hit(paddr, sysctrl_pkg::IDX_GENERAL_STATUS)) begin
                st_nxt.prdata = {31'h00000000, st_r.cal_pend}; // [RULE8]
            end else if (reg_hit(paddr, sysctrl_pkg::IDX_GENERAL_CONTROL)) begin
                st_nxt.prdata = {26'h0000000, st_r.em_split, st_r.wake_req};
            end else if (reg_hit(paddr, sysctrl_pkg::IDX_TIMER_CONTROL)) begin
                st_nxt.prdata = {28'h0000000, st_r.tctrl};
            end else if (reg_hit(paddr, sysctrl_pkg::IDX_TIMER_ON_RELOAD)) begin
                st_nxt.prdata = {16'h0000, st_r.on_cnt}; // [RULE17]
            end
        end

        // hold flags: set by hold-request, cleared by resume
        for (int i = 0; i < 4; i++) begin
            if (wr_done && reg_hit(paddr, sysctrl_pkg::IDX_TIMER_RESUME) && pwdata[i]) begin
                st_nxt.hold[i] = 1'b0; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE20]
            end
            if (wr_done && reg_hit(paddr, sysctrl_pkg::IDX_TIMER_HOLD_SET) && pwdata[i] &&
                !(i == sysctrl_pkg::HOLD_WDOG && wdog_reset_only)) begin
                st_nxt.hold[i] = 1'b1; // [RULE18] [RULE19] [RULE20]
            end
        end

        // effective holds including debug halt
        for (int i = 0; i < 4; i++) begin
            st_nxt.held[i] = st_nxt.hold[i] || (debug_halted && st_r.halt_hold_enable); // [RULE5] [RULE6]
        end
        if (debug_halted) begin // watchdog always held in halt
            st_nxt.held[sysctrl_pkg::HOLD_WDOG] = 1'b1; // [RULE7]
        end

        // plain control registers
        if (wr_done && reg_hit(paddr, sysctrl_pkg::IDX_DEBUG_HALT_CONTROL)) begin
            st_nxt.halt_hold_enable = pwdata[sysctrl_pkg::HALT_HOLD_EN_BIT];
        end
        st_nxt.cal_pend = otp_programmed && !calibration_done; // [RULE8]
        if (wr_done && reg_hit(paddr, sysctrl_pkg::IDX_GENERAL_CONTROL)) begin
            st_nxt.em_split = pwdata[sysctrl_pkg::EM_SPLIT_MSB:sysctrl_pkg::EM_SPLIT_LSB]; // [RULE9]
            st_nxt.wake_req = pwdata[sysctrl_pkg::WAKE_REQ_BIT];
        end
        em_dec = em_decode(st_nxt.em_split);
        st_nxt.em_rsv = em_dec[10]; // [RULE10]
        st_nxt.em_kb = em_dec[9:6]; // [RULE9] [RULE10]
        st_nxt.sys_kb = em_dec[5:0];
        if (wr_done && reg_hit(paddr, sysctrl_pkg::IDX_TIMER_CONTROL)) begin
            st_nxt.tctrl = pwdata[3:0];
        end
        if (wr_done && reg_hit(paddr, sysctrl_pkg::IDX_TIMER_ON_RELOAD)) begin
            st_nxt.on_reload = pwdata[15:0]; // [RULE17]
        end

        // radio wake sequencer, counts low-power ticks
        st_nxt.wake_irq = 1'b0;
        case (st_r.wk_state)
            sysctrl_pkg::WK_IDLE: begin // wait for request in deep sleep
                st_nxt.wk_cnt = 2'h0;
                if (st_r.wake_req && radio_deep_sleep) begin
                    st_nxt.wk_state = sysctrl_pkg::WK_WAIT;
                end
            end
            sysctrl_pkg::WK_WAIT: begin // third tick raises interrupt
                if (!st_r.wake_req) begin
                    st_nxt.wk_state = sysctrl_pkg::WK_IDLE;
                end else if (lp_tick) begin
                    st_nxt.wk_cnt = 2'(st_r.wk_cnt + 2'h1);
                    if (2'(st_r.wk_cnt + 2'h1) == sysctrl_pkg::WAKE_LP_TICKS) begin
                        st_nxt.wake_irq = 1'b1; // [RULE12]
                        st_nxt.wk_state = sysctrl_pkg::WK_DONE;
                    end
                end
            end
            sysctrl_pkg::WK_DONE: begin // rearm after request drops
                if (!st_r.wake_req) begin
                    st_nxt.wk_state = sysctrl_pkg::WK_IDLE;
                end
            end
            default: begin // unused code
                st_nxt.wk_state = sysctrl_pkg::WK_IDLE;
            end
        endcase

        // general timer ON counter
        tick_sel = st_r.tctrl[sysctrl_pkg::TC_SOURCE_BIT] ? fast_tick : slow_tick; // [RULE15]
        g_run = st_r.tctrl[sysctrl_pkg::TC_RUN_BIT] && !st_r.held[sysctrl_pkg::HOLD_GTIMER];
        on_tick = 1'b0;
        if (g_run && tick_sel) begin // prescaler
            if (st_r.tctrl[sysctrl_pkg::TC_BYPASS_BIT]) begin
                on_tick = 1'b1; // [RULE14]
            end else if (st_r.pre_cnt == 4'(sysctrl_pkg::PRESCALE_DIV - 1)) begin
                st_nxt.pre_cnt = 4'h0;
                on_tick = 1'b1; // [RULE14]
            end else begin
                st_nxt.pre_cnt = 4'(st_r.pre_cnt + 4'h1);
            end
        end
        if (on_tick) begin // count down, reload at zero
            st_nxt.on_cnt = (st_r.on_cnt == 16'h0000) ? st_r.on_reload : 16'(st_r.on_cnt - 16'h0001);
        end
        if (g_run && fast_tick) begin // fast clock halved
            st_nxt.fast_half = !st_r.fast_half; // [RULE13]
        end
        if (st_nxt.on_cnt != 16'h0000) begin // high time
            st_nxt.pulse = st_r.tctrl[sysctrl_pkg::TC_STYLE_BIT] ? st_nxt.fast_half : 1'b1; // [RULE13]
        end else begin
            st_nxt.pulse = 1'b0;
        end
        if (!st_r.tctrl[sysctrl_pkg::TC_RUN_BIT]) begin // off and in reset state
            st_nxt.on_cnt = 16'h0000; // [RULE16]
            st_nxt.pre_cnt = 4'h0;
            st_nxt.fast_half = 1'b0;
            st_nxt.pulse = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
            st_r.halt_hold_enable <= sysctrl_pkg::HALT_HOLD_EN_RST; // [RULE5]
            st_r.em_split <= sysctrl_pkg::EM_SPLIT_RST; // [RULE9]
            st_r.em_kb <= 4'h2;
            st_r.sys_kb <= 6'h30;
            st_r.wk_state <= sysctrl_pkg::WK_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state flops
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign watchdog_held = st_r.held[sysctrl_pkg::HOLD_WDOG];
    assign radio_timebase_held = st_r.held[sysctrl_pkg::HOLD_RADIO];
    assign sw_timer_held = st_r.held[sysctrl_pkg::HOLD_GTIMER];
    assign wakeup_timer_held = st_r.held[sysctrl_pkg::HOLD_WAKEUP];
    assign radio_wake_request = st_r.wake_req;
    assign lp_wake_irq = st_r.wake_irq;
    assign exchange_mem_kb = st_r.em_kb;
    assign system_mem_kb = st_r.sys_kb;
    assign exchange_mem_reserved = st_r.em_rsv;
    assign pulse_out = st_r.pulse;
    assign on_phase_counter = st_r.on_cnt;

    // write strobes seen by the checks
    logic wr_resume; // write to resume register
    logic wr_holdset; // write to hold-request register
    assign wr_resume = wr_done && reg_hit(paddr, sysctrl_pkg::IDX_TIMER_RESUME);
    assign wr_holdset = wr_done && reg_hit(paddr, sysctrl_pkg::IDX_TIMER_HOLD_SET);

    // resume of the watchdog
    AST_WDOG_RESUME: assert property (@(posedge clk) disable iff (rst) // [RULE1]
        wr_resume && pwdata[3] && !wr_holdset |=> !st_r.hold[3])
        else $error("watchdog hold not released");
    // resume of the radio timebase
    AST_RADIO_RESUME: assert property (@(posedge clk) disable iff (rst) // [RULE2]
        wr_resume && pwdata[2] |=> !st_r.hold[2])
        else $error("radio timebase hold not released");
    // resume zero leaves general timer hold
    AST_GTIMER_ZERO_IGNORED: assert property (@(posedge clk) disable iff (rst) // [RULE3]
        wr_resume && !pwdata[1] && st_r.hold[1] |=> st_r.hold[1])
        else $error("zero resume cleared general timer hold");
    // wake-up timer release shows on output at the same edge as its flag, checked at the second edge
    AST_WAKEUP_RESUME: assert property (@(posedge clk) disable iff (rst) // [RULE4]
        wr_resume && pwdata[0] && !debug_halted ##1 !debug_halted |=> !wakeup_timer_held)
        else $error("wake-up timer still held");
    // halt with enable holds every timer
    AST_HALT_ALL: assert property (@(posedge clk) disable iff (rst) // [RULE5]
        debug_halted && st_r.halt_hold_enable |=> watchdog_held && radio_timebase_held &&
        sw_timer_held && wakeup_timer_held)
        else $error("halt did not hold all timers");
    // halt without enable: radio timebase hold follows its flag
    AST_HALT_FLAGS: assert property (@(posedge clk) disable iff (rst) // [RULE6]
        debug_halted && !st_r.halt_hold_enable |=> radio_timebase_held == st_r.hold[2])
        else $error("radio hold ignores its flag in halt");
    // watchdog held in any halt
    AST_WDOG_HALT: assert property (@(posedge clk) disable iff (rst) // [RULE7]
        debug_halted |=> watchdog_held)
        else $error("watchdog ran during halt");
    // calibration flag follows its sources
    AST_CAL_PEND: assert property (@(posedge clk) disable iff (rst) // [RULE8]
        $stable(otp_programmed) && $stable(calibration_done) |=> st_r.cal_pend ==
        ($past(otp_programmed) && !$past(calibration_done)))
        else $error("calibration flag wrong");
    // split decode: code 0 and reserved codes
    AST_SPLIT_ZERO: assert property (@(posedge clk) disable iff (rst) // [RULE9]
        st_r.em_split == 5'h00 |=> exchange_mem_kb == 4'h0 && system_mem_kb == 6'h2A ||
        st_r.em_split != 5'h00)
        else $error("code 0 split wrong");
    AST_SPLIT_RSV: assert property (@(posedge clk) disable iff (rst) // [RULE10]
        (st_r.em_split == 5'h08 || st_r.em_split == 5'h10 || st_r.em_split > 5'h17) ##1
        $stable(st_r.em_split) |-> exchange_mem_reserved)
        else $error("reserved code not flagged");
    // wake interrupt: three ticks after the request
    sequence wake_armed_s;
        st_r.wk_state == sysctrl_pkg::WK_IDLE && st_r.wake_req && radio_deep_sleep;
    endsequence
    sequence wake_irq_s;
        ##[1:1000] lp_wake_irq;
    endsequence
    AST_WAKE_NO_EARLY: assert property (@(posedge clk) disable iff (rst) // [RULE12]
        wake_armed_s ##1 (!lp_tick) [*1] |-> st_r.wk_cnt == 2'h0 && !lp_wake_irq)
        else $error("wake interrupt early");
    AST_WAKE_IRQ: assert property (@(posedge clk) disable iff (rst) // [RULE12]
        lp_wake_irq |-> $past(st_r.wk_cnt) == 2'h2 && $past(lp_tick))
        else $error("wake interrupt not on third tick");
    // steady pulse in style zero
    AST_PULSE_STEADY: assert property (@(posedge clk) disable iff (rst) // [RULE13]
        !st_r.tctrl[3] && st_r.tctrl[0] && on_phase_counter != 16'h0000 && $stable(st_r.tctrl) |->
        pulse_out)
        else $error("pulse not steady high");
    // prescaler wraps at ten
    AST_PRESCALE: assert property (@(posedge clk) disable iff (rst) // [RULE14]
        st_r.pre_cnt <= 4'(sysctrl_pkg::PRESCALE_DIV - 1))
        else $error("prescaler past its limit");
    // stopped timer sits in reset
    AST_STOPPED: assert property (@(posedge clk) disable iff (rst) // [RULE16]
        !st_r.tctrl[0] |=> on_phase_counter == 16'h0000 && !pulse_out)
        else $error("stopped timer not reset");
    // watchdog hold refused in reset-only mode
    AST_WDOG_LOCK: assert property (@(posedge clk) disable iff (rst) // [RULE19]
        wr_holdset && wdog_reset_only && !st_r.hold[3] |=> !st_r.hold[3])
        else $error("watchdog hold taken in reset-only mode");
    // hold request sets a flag
    AST_HOLD_SET: assert property (@(posedge clk) disable iff (rst) // [RULE18]
        wr_holdset && pwdata[1] |=> st_r.hold[1])
        else $error("hold request lost");
endmodule : timer_freeze_sysctrl
`default_nettype wire

// ---- timer_freeze_sysctrl_test.sv ----
// self-checking testbench for the timer hold and system control bank
`timescale 1ns/1ns
`default_nettype none
module timer_freeze_sysctrl_test;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // bus and clocking
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd; // bus data
    logic pready, pslverr, err; // bus answer
    logic debug_halted = 1'b0, wdog_reset_only = 1'b0, otp_programmed = 1'b0, calibration_done = 1'b0;
    logic radio_deep_sleep = 1'b0, lp_tick = 1'b0, fast_tick = 1'b0, slow_tick = 1'b0; // tick enables
    logic watchdog_held, radio_timebase_held, sw_timer_held, wakeup_timer_held, radio_wake_request, lp_wake_irq;
    logic [3:0] exchange_mem_kb, held, mask; // memory size, held vector
    logic [5:0] system_mem_kb; // system memory size
    logic exchange_mem_reserved, pulse_out; // decode flag, pulse
    logic [15:0] on_phase_counter, lfsr_r = 16'hBD57, val, prev; // counter, random state
    logic [7:0] tick_cnt_r = 8'h00; // tick divider
    int error_cnt = 0, n_checks = 0, cnt, chg, tks; // tallies
    assign held = {watchdog_held, radio_timebase_held, sw_timer_held, wakeup_timer_held};
    // clock, 10 ns period
    always #5 clk = ~clk;
    // tick generators: fast every 2, low-power every 8, slow every 50 cycles
    always @(posedge clk) begin
        tick_cnt_r <= (tick_cnt_r == 8'hC7) ? 8'h00 : tick_cnt_r + 8'h01;
        fast_tick <= tick_cnt_r[0];
        lp_tick <= (tick_cnt_r[2:0] == 3'h7);
        slow_tick <= (tick_cnt_r % 50 == 0);
    end
    timer_freeze_sysctrl timer_freeze_sysctrl_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .debug_halted(debug_halted), .wdog_reset_only(wdog_reset_only), .otp_programmed(otp_programmed),
        .calibration_done(calibration_done), .radio_deep_sleep(radio_deep_sleep), .lp_tick(lp_tick),
        .fast_tick(fast_tick), .slow_tick(slow_tick), .watchdog_held(watchdog_held),
        .radio_timebase_held(radio_timebase_held), .sw_timer_held(sw_timer_held),
        .wakeup_timer_held(wakeup_timer_held), .radio_wake_request(radio_wake_request),
        .lp_wake_irq(lp_wake_irq), .exchange_mem_kb(exchange_mem_kb), .system_mem_kb(system_mem_kb),
        .exchange_mem_reserved(exchange_mem_reserved), .pulse_out(pulse_out),
        .on_phase_counter(on_phase_counter));
    // next pseudo-random value
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    // expected {reserved, exchange kB, system kB} for a split code
    function automatic logic [10:0] split_exp(input int c);
        if (c == 0) return {1'b0, 4'h0, 6'h2A};
        if (c <= 7) return {1'b0, 4'(c + 1), 6'(49 - c)};
        if (c >= 9 && c <= 15) return {1'b0, 4'(c - 5), 6'h28};
        if (c >= 17 && c <= 23) return {1'b0, 4'(c - 11), 6'h26};
        return {1'b1, 10'h000};
    endfunction : split_exp
    // compare and tally
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask : tk
    // one apb transfer; byte address is four times the register index
    task automatic apb(input logic wr, input logic [31:0] idx, input logic [31:0] wd);
        int w;
        w = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= idx << 2;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            w++;
        end while (pready !== 1'b1 && w < 20);
        if (w >= 20) chk("pready timeout", 32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // count counter steps and source ticks over a span
    task automatic measure(input logic src, input int span);
        chg = 0;
        tks = 0;
        prev = on_phase_counter;
        repeat (span) begin
            @(posedge clk);
            if (on_phase_counter !== prev) chg++;
            if (src ? fast_tick : slow_tick) tks++;
            prev = on_phase_counter;
        end
    endtask : measure
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run
    // watchdog against a hang
    initial begin
        #100000;
        error_cnt++;
        complete_run();
    end
    // main sequence
    initial begin
        tk(10);
        rst <= 1'b0;
        apb(1'b0, sysctrl_pkg::IDX_DEBUG_HALT_CONTROL, 32'h0); chk("halt enable reset", rd, 32'h1);
        apb(1'b0, sysctrl_pkg::IDX_GENERAL_CONTROL, 32'h0); chk("split reset", rd, 32'h2);
        apb(1'b0, sysctrl_pkg::IDX_TIMER_RESUME, 32'h0); chk("flags reset", rd, 32'h0);
        apb(1'b0, 32'h0000_0001, 32'h0); chk("unmapped error", {31'h0, err}, 32'h1);
        // random hold and resume patterns, zeros ignored
        for (int i = 0; i < 8; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            mask = lfsr_r[3:0];
            apb(1'b1, sysctrl_pkg::IDX_TIMER_HOLD_SET, {28'h0, mask}); tk(2);
            chk("held after hold", {28'h0, held}, {28'h0, mask});
            apb(1'b1, sysctrl_pkg::IDX_TIMER_RESUME, 32'h0); tk(2);
            chk("zero resume", {28'h0, held}, {28'h0, mask});
            apb(1'b1, sysctrl_pkg::IDX_TIMER_RESUME, {28'h0, lfsr_r[7:4]}); tk(2);
            chk("held after resume", {28'h0, held}, {28'h0, mask & ~lfsr_r[7:4]});
            apb(1'b1, sysctrl_pkg::IDX_TIMER_RESUME, 32'hF);
        end
        // watchdog not holdable in reset-only mode
        wdog_reset_only <= 1'b1;
        apb(1'b1, sysctrl_pkg::IDX_TIMER_HOLD_SET, 32'h8); tk(2);
        chk("reset-only hold", {31'h0, watchdog_held}, 32'h0);
        wdog_reset_only <= 1'b0;
        apb(1'b1, sysctrl_pkg::IDX_TIMER_RESUME, 32'hF);
        // debug halt with and without halt hold enable
        debug_halted <= 1'b1; tk(3);
        chk("halt holds all", {28'h0, held}, 32'hF);
        apb(1'b1, sysctrl_pkg::IDX_DEBUG_HALT_CONTROL, 32'h0);
        apb(1'b1, sysctrl_pkg::IDX_TIMER_HOLD_SET, 32'h2); tk(2);
        chk("halt follows flags", {28'h0, held}, 32'hA);
        debug_halted <= 1'b0;
        apb(1'b1, sysctrl_pkg::IDX_TIMER_RESUME, 32'hF);
        // calibration status for all input combinations
        for (int k = 0; k < 4; k++) begin
            otp_programmed <= k[1];
            calibration_done <= k[0];
            apb(1'b0, sysctrl_pkg::IDX_GENERAL_STATUS, 32'h0);
            chk("calibration pending", rd, {31'h0, k == 2});
        end
        // every split code
        for (int c = 0; c < 32; c++) begin
            apb(1'b1, sysctrl_pkg::IDX_GENERAL_CONTROL, 32'(c) << 1); tk(2);
            chk("split decode", exchange_mem_reserved ? {21'h0, 1'b1, 10'h0} :
                {21'h0, 1'b0, exchange_mem_kb, system_mem_kb}, {21'h0, split_exp(c)});
        end
        // wake request while the radio sleeps, held past one low-power period
        radio_deep_sleep <= 1'b1;
        apb(1'b1, sysctrl_pkg::IDX_GENERAL_CONTROL, 32'h3);
        cnt = 0;
        for (int w = 0; w < 100 && lp_wake_irq !== 1'b1; w++) begin
            @(posedge clk);
            if (lp_tick) cnt++;
        end
        chk("wake request out", {31'h0, radio_wake_request}, 32'h1);
        chk("wake delay", {31'h0, cnt >= 3 && cnt <= 4}, 32'h1);
        tk(8);
        apb(1'b1, sysctrl_pkg::IDX_GENERAL_CONTROL, 32'h2);
        // general timer: stopped reads live counter, then rates per source and prescale
        lfsr_r = lfsr_next(lfsr_r);
        val = lfsr_r | 16'h0200;
        apb(1'b1, sysctrl_pkg::IDX_TIMER_ON_RELOAD, {16'h0, val}); tk(2);
        chk("stopped counter", {16'h0, on_phase_counter}, 32'h0);
        apb(1'b0, sysctrl_pkg::IDX_TIMER_ON_RELOAD, 32'h0); chk("reload read", rd, 32'h0);
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, sysctrl_pkg::IDX_TIMER_CONTROL, (m == 0) ? 32'h7 : (m == 1) ? 32'h3 : 32'h5);
            measure(m != 2, 200);
            cnt = (m == 1) ? tks / 10 : tks;
            chk("counter rate", {31'h0, chg <= cnt + 1 && chg + 1 >= cnt}, 32'h1);
        end
        apb(1'b1, sysctrl_pkg::IDX_TIMER_CONTROL, 32'h7); tk(4);
        chk("steady pulse", {31'h0, pulse_out}, 32'h1);
        apb(1'b1, sysctrl_pkg::IDX_TIMER_HOLD_SET, 32'h2); tk(2);
        prev = on_phase_counter; tk(30);
        chk("held timer", {16'h0, on_phase_counter}, {16'h0, prev});
        apb(1'b1, sysctrl_pkg::IDX_TIMER_RESUME, 32'h2);
        apb(1'b1, sysctrl_pkg::IDX_TIMER_CONTROL, 32'hF);
        cnt = 0;
        prev = {15'h0, pulse_out};
        repeat (40) begin
            @(posedge clk);
            if (pulse_out !== prev[0]) cnt++;
            prev = {15'h0, pulse_out};
        end
        chk("toggled pulse", {31'h0, cnt > 4}, 32'h1);
        apb(1'b1, sysctrl_pkg::IDX_TIMER_CONTROL, 32'h0); tk(3);
        chk("timer reset", {16'h0, on_phase_counter}, 32'h0);
        complete_run();
    end
endmodule : timer_freeze_sysctrl_test
`default_nettype wire
